/* sensor_two_wire_slave_port_test.sv */
// Purpose: self-checking bench for the sensor two-wire slave port
// Assumes: bus master model drives the pins; strap follows mode
// Notes:   shortened load and hang counts keep the run brief
`timescale 1ns/1ns
module sensor_two_wire_slave_port_test;
  import tsp_pkg::*;
  localparam int unsigned NVL = 1000; // short nonvolatile load
  logic        clk, rstn, scl, sda_m, a, alert_active, alert_high;
  logic        sda_oe, sda_out, alert_clear, ready_clear;
  logic [1:0]  mode;       // strap wiring: gnd, supply, data, clock
  logic [2:0]  conv_flags;
  logic [15:0] thermal_value, nvm_setup, nvm_upper, nvm_lower, v;
  logic [15:0] setup_control, upper_threshold, lower_threshold;
  logic [63:0] nvm_scratch;
  logic [15:0] m [16];     // expected register contents
  logic [7:0]  p, q, d8, cp; // cp: pointer the port should hold
  int          failures, n_compared, clr_cnt, rdy_cnt;
  wire         sda   = sda_m & ~(sda_oe & ~sda_out); // pull-up
  wire         strap = mode[1] ? (mode[0] ? scl : sda) : mode[0];

  tsp_bus_master i_tsp_bus_master (.scl, .sda_m, .sda);
  tsp_slave_port #(.TIMEOUT_CYCLES(2000), .NVLOAD_CYCLES(NVL))
    i_tsp_slave_port (.clk, .rstn, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .address_strap_pin(strap), .thermal_value, .conv_flags,
    .alert_active, .alert_high, .nvm_setup, .nvm_upper, .nvm_lower,
    .nvm_scratch, .setup_control, .upper_threshold, .lower_threshold,
    .alert_clear, .ready_clear);

  initial clk = 1'b0;
  always #4 clk = ~clk;
  // count clear pulses so a window can be judged afterwards
  always @(posedge clk) if (alert_clear === 1'b1) clr_cnt <= clr_cnt + 1;
  always @(posedge clk) if (ready_clear === 1'b1) rdy_cnt <= rdy_cnt + 1;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bx(input logic [7:0] d, input logic mk);
    i_tsp_bus_master.xfer(d, mk, q, a);
  endtask

  function automatic logic [7:0] adr(input logic rw);
    return {ADDR_HI, mode, rw};
  endfunction

  // expected read word for a pointer
  function automatic logic [15:0] rexp(input logic [7:0] pt);
    if (pt == PTR_READING) return thermal_value;
    if (pt == PTR_SETUP) return {conv_flags, 13'h0} | m[1];
    return (pt < 8'h10) ? m[pt[3:0]] : WORD_ZERO;
  endfunction

  // new stored reset values
  task automatic rnd_nvm();
    nvm_setup   = 16'($urandom);
    nvm_upper   = 16'($urandom);
    nvm_lower   = 16'($urandom);
    nvm_scratch = {$urandom, $urandom};
  endtask

  // expected contents once a load has landed
  task automatic load_m();
    m = '{default: WORD_ZERO};
    m[1] = nvm_setup & SETUP_WR_MASK;
    m[2] = nvm_upper;
    m[3] = nvm_lower;
    for (int i = 0; i < 4; i++) m[5+i] = nvm_scratch[16*i +: 16];
    m[15] = PART_ID_VAL;
  endtask

  task automatic outs();
    chk(setup_control, m[1]);
    chk(upper_threshold, m[2]);
    chk(lower_threshold, m[3]);
  endtask

  // pointer write, then both bytes of v when n > 0, high byte first
  task automatic wr(input logic [7:0] pt, input int n);
    cp = pt;
    i_tsp_bus_master.strt();
    bx(adr(1'b0), 1'b1);
    chk(a, 1'b0);
    bx(pt, 1'b1);
    chk(a, 1'b0);
    if (n > 0) begin
      bx(v[15:8], 1'b1);
      chk(a, 1'b0);
      bx(v[7:0], 1'b1);
      chk(a, 1'b0);
    end
    i_tsp_bus_master.stp();
  endtask

  // read a word, acknowledging the high byte only
  task automatic rd(input logic [15:0] e);
    int c, r;
    c = clr_cnt;
    r = rdy_cnt;
    i_tsp_bus_master.strt();
    bx(adr(1'b1), 1'b1);
    chk(a, 1'b0);
    bx(8'hff, 1'b0);
    d8 = q;
    bx(8'hff, 1'b1);
    i_tsp_bus_master.stp();
    chk({d8, q}, e);
    // result and setup reads clear ready; setup read clears alert outside hysteresis mode
    chk(16'(rdy_cnt - r), cp <= PTR_SETUP);
    chk(16'(clr_cnt - c), cp == PTR_SETUP && !m[1][SETUP_THERM]);
  endtask

  // alert response; d is what other responders pull onto the line
  task automatic ara(input logic [7:0] d, input logic act);
    int         c;
    logic [7:0] own;
    c = clr_cnt;
    alert_active = act;
    alert_high = 1'($urandom);
    own = {ADDR_HI, mode, alert_high};
    i_tsp_bus_master.strt();
    bx(ARA_BYTE, 1'b1);
    chk(a, !act);
    if (act) begin
      bx(d, 1'b1);
      chk(q, own & d);
    end
    i_tsp_bus_master.stp();
    repeat (4) @(posedge clk);
    #1;
    chk(16'(clr_cnt - c),
        act && (own & ~d) == 0 && !m[1][SETUP_THERM]);
  endtask

  initial begin
    rstn = 1'b0;
    mode = 2'h0;
    alert_active = 1'b0;
    alert_high = 1'b0;
    cp = PTR_RESET;
    void'($urandom(32'h78d6));
    thermal_value = 16'($urandom);
    conv_flags = 3'($urandom);
    rnd_nvm();
    repeat (3) @(posedge clk);
    #1;
    chk(setup_control, SETUP_RST);
    chk(upper_threshold, UPPER_RST);
    chk(lower_threshold, LOWER_RST);
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // reads served and writes dropped while the load runs
    rd(thermal_value);
    v = 16'($urandom);
    wr(PTR_UPPER, 2);
    chk(upper_threshold, UPPER_RST);
    repeat (NVL) @(posedge clk);
    #1;
    load_m();
    outs();
    for (int i = 0; i < 16; i++) begin
      mode = 2'($urandom);
      thermal_value = 16'($urandom);
      conv_flags = 3'($urandom);
      p = (i % 3 == 0) ? 8'($urandom) : 8'($urandom_range(8, 1));
      v = 16'($urandom);
      wr(p, 2);
      if (p >= 1 && p <= 8) m[p[3:0]] = v & (p == PTR_SETUP ?
          SETUP_WR_MASK : p == PTR_UNLOCK ? 16'h8000 : 16'hffff);
      outs();
      rd(rexp(p));
      p = (i % 4 == 0) ? PTR_PART_ID : 8'($urandom_range(8, 0));
      wr(p, 0);
      rd(rexp(p));
      rd(rexp(p));
      // same upper bits, other strap code: must be ignored
      i_tsp_bus_master.strt();
      bx(adr(1'b0) ^ 8'h02, 1'b1);
      chk(a, 1'b1);
      i_tsp_bus_master.stp();
      ara(8'h90, 1'b1);
      ara(8'hff, i[0]);
    end
    // general-call reset reloads the stored values, pointer back to 0
    rnd_nvm();
    i_tsp_bus_master.strt();
    bx(GC_ADDR_BYTE, 1'b1);
    chk(a, 1'b0);
    bx(GC_RESET_CMD, 1'b1);
    chk(a, 1'b0);
    i_tsp_bus_master.stp();
    cp = PTR_RESET;
    repeat (NVL + 20) @(posedge clk);
    #1;
    load_m();
    outs();
    thermal_value = 16'($urandom) & 16'h7fff;
    rd(rexp(PTR_READING));
    // hung clock while the port pulls data low for a zero bit
    i_tsp_bus_master.strt();
    bx(adr(1'b1), 1'b1);
    i_tsp_bus_master.hang(10);
    chk(sda_oe, 1'b1);
    i_tsp_bus_master.hang(2100);
    chk(sda_oe, 1'b0);
    i_tsp_bus_master.stp();
    rd(rexp(PTR_READING));
    final_report();
  end

  // watchdog against a hang; a clean run needs about 40k cycles
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule

/* tsp_bus_master.sv */
// Purpose: behavioural two-wire bus master facing the slave port
// Assumes: data line has a pull-up; bus clock idles high between frames
// Notes:   80 ns bus clock; every step is a whole system clock period
`timescale 1ns/1ns
module tsp_bus_master (
  output logic      scl,   // bus clock, only the master drives it
  output logic      sda_m, // 0 pulls data low, 1 releases it
  input  wire logic sda    // resolved data line
);
  // idle bus: both lines high
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // one bit: data moves mid-low, sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    scl = 1'b0;
    #16 sda_m = b;
    #24 scl = 1'b1;
    #32 r = sda;
    #8;
  endtask

  // start or repeated start
  task automatic strt();
    scl = 1'b0;
    #16 sda_m = 1'b1;
    #24 scl = 1'b1;
    #40 sda_m = 1'b0;
    #40;
  endtask

  // stop, leaving the bus idle
  task automatic stp();
    scl = 1'b0;
    #16 sda_m = 1'b0;
    #24 scl = 1'b1;
    #40 sda_m = 1'b1;
    #40;
  endtask

  // eight bits out or in, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mack, ack);
  endtask

  // hold the clock low; a hung master, used to trip the timeout
  task automatic hang(input int n);
    scl = 1'b0;
    #(8 * n);
  endtask
endmodule

/* tsp_pkg.sv */
// Purpose: shared constants and types for the sensor two-wire slave port
// Assumes: 125 MHz system clock, registers reached only over the two-wire bus
// Notes:   every offset, reset value and cycle count lives here
package tsp_pkg;

  // system clock rate and derived timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TIMEOUT_MS    = 35;   // bus hang limit, ms
  localparam int unsigned NVLOAD_US     = 1500; // nonvolatile load time, us
  // longest times round down to whole cycles
  localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned NVLOAD_CYC    = NVLOAD_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W         = 23;   // holds either count

  // bus framing
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [4:0] ADDR_HI        = 5'h12;  // upper five bits 10010
  localparam logic [7:0] GC_ADDR_BYTE   = 8'h00;  // general call, write
  localparam logic [7:0] GC_RESET_CMD   = 8'h06;  // general-call reset
  localparam logic [7:0] ARA_BYTE       = 8'h19;  // alert response, read
  localparam logic [1:0] STRAP_RST      = 2'h0;

  // register pointer values
  localparam logic [7:0] PTR_READING    = 8'h00;
  localparam logic [7:0] PTR_SETUP      = 8'h01;
  localparam logic [7:0] PTR_UPPER      = 8'h02;
  localparam logic [7:0] PTR_LOWER      = 8'h03;
  localparam logic [7:0] PTR_UNLOCK     = 8'h04;
  localparam logic [7:0] PTR_SCRATCH1   = 8'h05;
  localparam logic [7:0] PTR_SCRATCH4   = 8'h08;
  localparam logic [7:0] PTR_PART_ID    = 8'h0f;
  localparam logic [7:0] PTR_RESET      = 8'h00;

  // reset values before the nonvolatile load lands
  localparam logic [15:0] SETUP_RST     = 16'h0220;
  localparam logic [15:0] UPPER_RST     = 16'h6000;
  localparam logic [15:0] LOWER_RST     = 16'h8000;
  localparam logic [15:0] UNLOCK_RST    = 16'h0000;
  localparam logic [15:0] SCRATCH_RST   = 16'h0000;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  // arbitrary identity value, not that of any real part
  localparam logic [15:0] PART_ID_VAL   = 16'h0a5c;

  // field layouts
  localparam logic [15:0] SETUP_WR_MASK = 16'h0ffc; // bits 11:2 writable
  localparam int unsigned SETUP_THERM   = 4;        // hysteresis_window_select
  localparam int unsigned UNLOCK_BIT    = 15;

  // bit-level bus phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_RX   = 3'b001,
    PH_ACK  = 3'b010,
    PH_TX   = 3'b011,
    PH_MACK = 3'b100
  } tsp_phase_t;

  // meaning of the byte being moved
  typedef enum logic [2:0] {
    K_ADDR  = 3'b000,
    K_PTR   = 3'b001,
    K_WDATA = 3'b010,
    K_GCCMD = 3'b011,
    K_READ  = 3'b100,
    K_ARA   = 3'b101
  } tsp_kind_t;

endpackage

/* tsp_slave_port.sv */
// Purpose: two-wire slave port of a temperature sensor with its registers
// Assumes: scl, sda and strap pins are asynchronous; sensor inputs are
//          on clk
// Notes:   open-drain data pin as sda_out/sda_oe; no clock output exists
//
// Summary of operation
// - slave only, never drives the clock line
// - works for bus clock 1 kHz to 400 kHz
// - sixteen-bit words move high byte first
// - address 10010 plus two strap-decoded bits
// - acknowledge holds data low through ninth clock
// - data changes while clock high mean START/STOP
// - first written byte becomes the pointer, acknowledged
// - later written bytes go to pointed register
// - reads use last pointer, kept across reads
// - transmit high then low; master no-ack ends
// - alert response returns address with side bit
// - bitwise arbitration on response; winner clears alert outside hysteresis mode
// - general call acknowledged; 06 command resets registers
// - hang of 35 ms resets the interface
// - any number of bytes per transfer, except the single-byte alert response
// - register reset values come from nonvolatile cells, except the unlock word
// - eight-bit pointer resets to zero
// - hysteresis mode: reads never clear the alert
// - writes ignored during nonvolatile load, reads served
`timescale 1ns/1ns
module tsp_slave_port
  import tsp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned NVLOAD_CYCLES  = NVLOAD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        scl_in,            // bus clock pin level
  input  wire logic        sda_in,            // bus data pin level
  output logic             sda_out,           // always low when enabled
  output logic             sda_oe,            // high pulls data low
  input  wire logic        address_strap_pin, // strap pin level
  input  wire logic [15:0] thermal_value,     // latest conversion result
  input  wire logic [2:0]  conv_flags,        // high, low, ready flags
  input  wire logic        alert_active,      // alert output asserted
  input  wire logic        alert_high,        // alert is over upper limit
  input  wire logic [15:0] nvm_setup,         // stored reset values
  input  wire logic [15:0] nvm_upper,
  input  wire logic [15:0] nvm_lower,
  input  wire logic [63:0] nvm_scratch,       // four stored words
  output logic [15:0]      setup_control,
  output logic [15:0]      upper_threshold,
  output logic [15:0]      lower_threshold,
  output logic             alert_clear,       // one-cycle clear request
  output logic             ready_clear        // one-cycle ready clear
);

  logic [2:0]       pins_s;       // synchronised scl, sda, strap
  logic             scl_s;
  logic             sda_s;
  logic             strap_s;
  logic             scl_d;        // previous synchronised levels
  logic             sda_d;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  tsp_phase_t       phase;
  tsp_kind_t        kind;
  logic [3:0]       cnt;          // bits moved in this byte
  logic [7:0]       shreg;        // receive shifter
  logic [7:0]       tx_shift;     // transmit shifter, bit 7 on the wire
  logic [7:0]       ptr;          // register pointer
  logic             byte_hi;      // next byte is the high half
  logic [7:0]       hi_hold;      // written high byte awaiting low
  logic [15:0]      rd_word;      // word frozen for both halves
  logic [15:0]      rd_now;       // live read mux
  logic [15:0]      wr_data;
  logic             wr_en;
  logic             soft_rst;
  logic             strap_at_start;
  logic             strap_at_low;
  logic             strap_at_rise;
  logic [1:0]       strap_code;   // last decoded strap bits
  logic [1:0]       addr_low;
  logic [15:0]      unlock_word;
  logic [15:0]      scratch [4];
  logic [CNT_W-1:0] nv_cnt;
  logic             nv_busy;
  logic             load_done;
  logic [CNT_W-1:0] to_cnt;
  logic             to_hit;
  logic             therm;
  logic [7:0]       tx_next;      // byte that starts the next transmit

  // decode strap from levels seen at start, clock low, first rise
  function automatic logic [1:0] strap_decode(input logic at_start,
                                              input logic at_low,
                                              input logic at_rise);
    if (!at_start)
      strap_decode = at_rise ? 2'h2 : 2'h0; // data-tied or ground
    else
      strap_decode = at_low ? 2'h1 : 2'h3;  // supply or clock-tied
  endfunction

  // pins cross into clk before anything looks at them
  tsp_sync #(.W(3)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({scl_in, sda_in, address_strap_pin}),
    .q    (pins_s)
  );

  assign scl_s   = pins_s[2];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[0];
  assign therm   = setup_control[SETUP_THERM];

  // edge history; 125 MHz oversamples a 400 kHz bus many times over
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // bits are taken on rising clock; data moves only while clock is low
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // strap capture at three moments of each address byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_at_start <= 1'b0;
      strap_at_low   <= 1'b0;
      strap_at_rise  <= 1'b0;
      strap_code     <= STRAP_RST;
    end else begin
      if (start_det)
        strap_at_start <= strap_s;
      if (scl_fall && phase == PH_RX && kind == K_ADDR && cnt == 4'h0)
        strap_at_low <= strap_s;
      if (scl_rise && phase == PH_RX && kind == K_ADDR && cnt == 4'h0)
        strap_at_rise <= strap_s;
      // only a leading one makes the rise sample meaningful
      if (scl_fall && phase == PH_RX && kind == K_ADDR &&
          cnt == BYTE_BITS && shreg[7])
        strap_code <= addr_low;
    end
  end

  assign addr_low = shreg[7] ? strap_decode(strap_at_start, strap_at_low,
                                            strap_at_rise) : strap_code;

  // live read mux; unmapped addresses read as zero
  always_comb begin
    rd_now = WORD_ZERO;
    case (ptr)
      PTR_READING: rd_now = thermal_value;
      PTR_SETUP:   rd_now = {conv_flags, nv_busy, setup_control[11:0]};
      PTR_UPPER:   rd_now = upper_threshold;
      PTR_LOWER:   rd_now = lower_threshold;
      PTR_UNLOCK:  rd_now = {unlock_word[15], nv_busy, 14'h0000};
      PTR_PART_ID: rd_now = PART_ID_VAL;
      default: begin
        if (ptr >= PTR_SCRATCH1 && ptr <= PTR_SCRATCH4)
          rd_now = scratch[2'(ptr - PTR_SCRATCH1)];
      end
    endcase
  end

  // high half is freshly latched, low half comes from the frozen word
  assign tx_next = byte_hi ? rd_now[15:8] : rd_word[7:0];

  // byte and bit sequencer
  always_ff @(posedge clk) begin
    wr_en       <= 1'b0;
    soft_rst    <= 1'b0;
    alert_clear <= 1'b0;
    ready_clear <= 1'b0;
    if (!rstn) begin
      phase    <= PH_IDLE;
      kind     <= K_ADDR;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      tx_shift <= 8'h00;
      sda_oe   <= 1'b0;
      ptr      <= PTR_RESET;
      byte_hi  <= 1'b1;
      hi_hold  <= 8'h00;
      rd_word  <= WORD_ZERO;
      wr_data  <= WORD_ZERO;
    end else if (to_hit) begin
      phase  <= PH_IDLE;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      phase  <= PH_IDLE;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      phase  <= PH_RX;   // repeated start also lands here
      kind   <= K_ADDR;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
    end else if (soft_rst) begin
      ptr <= PTR_RESET;
    end else if (scl_rise) begin
      case (phase)
        PH_RX: begin
          shreg <= {shreg[6:0], sda_s};
          cnt   <= cnt + 4'h1;
        end
        PH_TX: begin
          cnt <= cnt + 4'h1;
          // sent a one but the wire is low: a lower address won
          if (kind == K_ARA && !sda_oe && !sda_s)
            phase <= PH_IDLE;
        end
        PH_MACK: begin
          if (sda_s)
            phase <= PH_IDLE;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (phase)
        PH_RX: begin
          if (cnt == BYTE_BITS) begin
            cnt <= 4'h0;
            case (kind)
              K_ADDR: begin
                if (shreg[7:1] == {ADDR_HI, addr_low}) begin
                  sda_oe  <= 1'b1;
                  phase   <= PH_ACK;
                  kind    <= shreg[0] ? K_READ : K_PTR;
                  byte_hi <= 1'b1;
                end else if (shreg == GC_ADDR_BYTE) begin
                  sda_oe <= 1'b1;
                  phase  <= PH_ACK;
                  kind   <= K_GCCMD;
                end else if (shreg == ARA_BYTE && alert_active) begin
                  sda_oe <= 1'b1;
                  phase  <= PH_ACK;
                  kind   <= K_ARA;
                end else begin
                  phase <= PH_IDLE; // not for us
                end
              end
              K_PTR: begin
                ptr     <= shreg;
                sda_oe  <= 1'b1;
                phase   <= PH_ACK;
                kind    <= K_WDATA;
                byte_hi <= 1'b1;
              end
              K_WDATA: begin
                sda_oe  <= 1'b1;
                phase   <= PH_ACK;
                byte_hi <= ~byte_hi;
                if (byte_hi) begin
                  hi_hold <= shreg;
                end else begin
                  wr_en   <= ~nv_busy;
                  wr_data <= {hi_hold, shreg};
                end
              end
              K_GCCMD: begin
                sda_oe <= 1'b1;
                phase  <= PH_ACK;
                if (shreg == GC_RESET_CMD)
                  soft_rst <= 1'b1;
              end
              default: phase <= PH_IDLE;
            endcase
          end
        end
        PH_ACK: begin
          cnt <= 4'h0;
          if (kind == K_READ) begin
            phase    <= PH_TX;
            rd_word  <= rd_now;
            tx_shift <= tx_next;
            sda_oe   <= ~tx_next[7];
            byte_hi  <= 1'b0;
            ready_clear <= (ptr == PTR_READING) || (ptr == PTR_SETUP);
            alert_clear <= (ptr == PTR_SETUP) && !therm;
          end else if (kind == K_ARA) begin
            phase    <= PH_TX;
            tx_shift <= {ADDR_HI, strap_code, alert_high};
            sda_oe   <= ~ADDR_HI[4];
          end else begin
            phase  <= PH_RX;
            sda_oe <= 1'b0;
          end
        end
        PH_TX: begin
          if (cnt == BYTE_BITS) begin
            sda_oe <= 1'b0;
            phase  <= PH_MACK;
            if (kind == K_ARA && !therm)
              alert_clear <= 1'b1;
          end else begin
            sda_oe   <= ~tx_shift[6];
            tx_shift <= {tx_shift[6:0], 1'b0};
          end
        end
        PH_MACK: begin
          cnt <= 4'h0;
          if (kind == K_ARA) begin
            phase <= PH_IDLE; // response is a single byte
          end else begin
            phase    <= PH_TX;
            tx_shift <= tx_next;
            sda_oe   <= ~tx_next[7];
            byte_hi  <= ~byte_hi;
            if (byte_hi)
              rd_word <= rd_now;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  // nonvolatile load timer; general-call reset restarts it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nv_cnt    <= '0;
      nv_busy   <= 1'b1;
      load_done <= 1'b0;
    end else begin
      load_done <= 1'b0;
      if (soft_rst) begin
        nv_cnt  <= '0;
        nv_busy <= 1'b1;
      end else if (nv_busy) begin
        nv_cnt <= nv_cnt + 1'b1;
        if (nv_cnt == CNT_W'(NVLOAD_CYCLES - 1)) begin
          nv_busy   <= 1'b0;
          load_done <= 1'b1;
        end
      end
    end
  end

  // register file; the load wins over a write landing the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      setup_control   <= SETUP_RST;
      upper_threshold <= UPPER_RST;
      lower_threshold <= LOWER_RST;
      unlock_word     <= UNLOCK_RST;
      for (int i = 0; i < 4; i++)
        scratch[i] <= SCRATCH_RST;
    end else if (load_done) begin
      setup_control   <= nvm_setup & SETUP_WR_MASK;
      upper_threshold <= nvm_upper;
      lower_threshold <= nvm_lower;
      for (int i = 0; i < 4; i++)
        scratch[i] <= nvm_scratch[16*i +: 16];
    end else if (soft_rst) begin
      unlock_word <= UNLOCK_RST; // relock on reset
    end else if (wr_en) begin
      case (ptr)
        PTR_SETUP:  setup_control   <= wr_data & SETUP_WR_MASK;
        PTR_UPPER:  upper_threshold <= wr_data;
        PTR_LOWER:  lower_threshold <= wr_data;
        PTR_UNLOCK: unlock_word     <= {wr_data[UNLOCK_BIT], 15'h0000};
        default: begin
          // read-only and unmapped pointers fall through untouched
          if (ptr >= PTR_SCRATCH1 && ptr <= PTR_SCRATCH4)
            scratch[2'(ptr - PTR_SCRATCH1)] <= wr_data;
        end
      endcase
    end
  end

  // hang timer: clock held low or our own data drive, inside a frame
  always_ff @(posedge clk) begin
    if (!rstn || phase == PH_IDLE || (scl_s && !sda_oe))
      to_cnt <= '0;
    else
      to_cnt <= to_cnt + 1'b1;
  end

  assign to_hit = (to_cnt == CNT_W'(TIMEOUT_CYCLES - 1));

  // ---- checks on the driven behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_stop_seen;
    stop_det && !to_hit;
  endsequence

  sequence s_released_idle;
    phase == PH_IDLE && !sda_oe;
  endsequence

  property p_ack_low;
    phase == PH_ACK |-> sda_oe;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("data released during acknowledge");

  property p_stop_idle;
    s_stop_seen |=> s_released_idle;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return port to idle");

  property p_timeout;
    to_hit |=> s_released_idle;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("hang timeout did not release the bus");

  property p_ptr_load;
    scl_fall && phase == PH_RX && kind == K_PTR && cnt == BYTE_BITS &&
      !to_hit && !stop_det && !start_det && !soft_rst
      |=> ptr == $past(shreg) && sda_oe;
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer byte not stored or not acknowledged");

  property p_ptr_hold;
    phase == PH_TX |=> $stable(ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer changed during a read");

  property p_busy_nowrite;
    nv_busy ##1 nv_busy |-> $stable(upper_threshold);
  endproperty
  a_busy_nowrite: assert property (p_busy_nowrite)
    else $error("register changed during nonvolatile load");

  property p_therm_keep;
    alert_clear |-> !$past(therm);
  endproperty
  a_therm_keep: assert property (p_therm_keep)
    else $error("alert cleared in hysteresis mode");

  property p_gc_reset;
    soft_rst |=> ptr == PTR_RESET ##[1:2] nv_busy;
  endproperty
  a_gc_reset: assert property (p_gc_reset)
    else $error("general-call reset did not restart load");

endmodule

/* tsp_sync.sv */
// Purpose: two-flop synchroniser for the asynchronous bus pins
// Assumes: inputs are slow levels compared with the system clock
// Notes:   only the second stage leaves this module
`timescale 1ns/1ns
module tsp_sync
  import tsp_pkg::*;
#(
  parameter int unsigned W = 3
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta; // first stage, read by q alone

  // idle bus is high, so reset to all ones
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
